// ==== bench/can_bus_model.sv ====
/*
  behavioural model of the bus side: wired bus level, other nodes and the receive pin readback.
  assumes the block drives its output stages through drive level and output enable.
*/
`timescale 1ns/1ps
module can_bus_model (
  input  wire logic i_drv_dominant,  // level the block puts on its stages
  input  wire logic i_drv_oe,        // stages enabled
  input  wire logic i_bus_rx_pin,    // receive output of the block
  input  wire logic i_force_dom,     // another node holds the bus dominant
  input  wire logic i_rx_short,      // receive pin shorted to the recessive level
  output logic      o_bus_diff,      // receiver level, 0 = dominant
  output logic      o_rx_fb          // readback of the receive pin
);
  // wired bus: any node driving dominant wins, a disabled stage never does
  assign o_bus_diff = !((i_drv_oe && i_drv_dominant) || i_force_dom);
  // a short pulls the readback recessive whatever the block drives
  assign o_rx_fb    = i_bus_rx_pin | i_rx_short;
endmodule

// ==== bench/can_transceiver_mode_control_tb_top.sv ====
/*
  testbench for the transceiver mode and wake control block, with the bus model beside it.
  assumes shortened timing parameters and the command and read pulses of the block.
*/
`timescale 1ns/1ps
module can_transceiver_mode_control_tb_top;
  import can_mode_pkg::*;
  logic          clk, nrst, status_rd, int_mask, tx_in, uv_off;  // drives
  logic          force_dom, rx_short, restart_seen;              // bus and monitors
  logic          devel;                                          // devel strap
  logic [2:0]    rd_addr;                                        // status read address
  chip_mode_type chip;                                           // chip mode input
  mode_cmd_type  mode_cmd;                                       // command pulse
  logic          bus_diff, rx_fb, rx_pin, drv_dom, drv_oe, split_en, int_n, restart_req;
  xcvr_mode_type mode;                                           // mode output
  logic [15:0]   status;                                         // read data
  int            mismatches, total_checks, cycles;               // tallies
  can_transceiver_mode_control #(.WAKE_FILTER_P(8), .TXD_TO_P(8), .BUS_TO_P(16),
    .RXD_STUCK_P(8)) can_transceiver_mode_control_inst (
    .i_clk(clk), .i_nrst(nrst), .i_chip_mode(chip), .i_sw_devel(devel),
    .i_mode_cmd(mode_cmd), .i_status_rd(status_rd), .i_status_addr(rd_addr),
    .i_int_mask(int_mask), .i_bus_tx_input(tx_in), .i_bus_diff(bus_diff),
    .i_bus_rx_pin_fb(rx_fb), .i_supply_undervoltage_off(uv_off), .o_bus_rx_pin(rx_pin),
    .o_drv_dominant(drv_dom), .o_drv_oe(drv_oe), .o_split_en(split_en), .o_int_n(int_n),
    .o_restart_req(restart_req), .o_mode(mode), .o_status_data(status));
  can_bus_model can_bus_model_inst (
    .i_drv_dominant(drv_dom), .i_drv_oe(drv_oe), .i_bus_rx_pin(rx_pin),
    .i_force_dom(force_dom), .i_rx_short(rx_short), .o_bus_diff(bus_diff), .o_rx_fb(rx_fb));
  // clock at 4 ns period
  always #2 clk = ~clk;
  // catches the one-cycle restart pulse; cycle ceiling cuts a hang short
  always @(posedge clk) begin
    if (restart_req === 1'b1) restart_seen = 1'b1;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait n edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle mode command, then let the mode settle
  task automatic cmd(input xcvr_mode_type m);
    mode_cmd = '{valid: 1'b1, mode: m};
    tick(1);
    mode_cmd.valid = 1'b0;
    tick(3);
  endtask
  // status read pulse; data one cycle later
  task automatic rd(input logic [15:0] exp);
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    tick(2);
    check(status, exp);
  endtask
  // remote node holds dominant past the wake filter
  task automatic wake();
    force_dom = 1'b1;
    tick(10);
    force_dom = 1'b0;
    tick(3);
  endtask
  task automatic done(input string name);
    $display("end of test %s", name);
  endtask
  // closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    clk = 0; nrst = 0; status_rd = 0; int_mask = 0; tx_in = 1; uv_off = 0;
    force_dom = 0; rx_short = 0; restart_seen = 0; chip = CHIP_INIT;
    devel = 0; rd_addr = 3'h0;
    mode_cmd = '{valid: 1'b0, mode: XCVR_OFF};
    tick(20);
    nrst = 1;
    tick(3);
    check(16'(mode), 16'(XCVR_OFF));
    check(16'({rx_pin, int_n}), 16'h0003);
    rd(WAKE_STATUS_RST);
    done("reset");
    chip = CHIP_NORMAL;
    cmd(XCVR_NORMAL);
    check(16'(mode), 16'(XCVR_NORMAL));
    check(16'({split_en, drv_oe}), 16'h0003);
    tx_in = 0;
    tick(2);
    check(16'(drv_dom), 16'h0001);
    check(16'(rx_pin), 16'h0000);
    tx_in = 1;
    tick(2);
    check(16'(rx_pin), 16'h0001);
    done("normal");
    cmd(XCVR_RX_ONLY);
    check(16'({split_en, drv_oe}), 16'h0002);
    force_dom = 1;
    tick(3);
    check(16'(rx_pin), 16'h0000);
    force_dom = 0;
    tick(2);
    done("rx only");
    chip = CHIP_STOP;
    devel = 1;
    tick(2);
    cmd(XCVR_NORMAL);
    check(16'(mode), 16'(XCVR_RX_ONLY));
    devel = 0;
    cmd(XCVR_WAKE);
    check(16'({mode, split_en}), 16'({XCVR_WAKE, 1'b0}));
    wake();
    check(16'({restart_seen, int_n, rx_pin}), 16'h0000);
    rd_addr = 3'h1;
    rd(16'h0000);
    rd_addr = 3'h0;
    rd(16'h0001);
    rd(16'h0000);
    cmd(XCVR_WAKE);
    wake();
    rd(16'h0000);
    cmd(XCVR_OFF);
    cmd(XCVR_WAKE);
    check(16'(mode), 16'(XCVR_WAKE));
    done("stop wake");
    cmd(XCVR_OFF);
    wake();
    check(16'(int_n), 16'h0001);
    rd(16'h0000);
    done("off");
    cmd(XCVR_WAKE);
    chip = CHIP_SLEEP;
    restart_seen = 0;
    wake();
    check(16'({restart_seen, int_n, rx_pin}), 16'h0006);
    rd(16'h0001);
    done("sleep wake");
    chip = CHIP_NORMAL;
    int_mask = 1;
    cmd(XCVR_OFF);
    cmd(XCVR_WAKE);
    wake();
    check(16'(int_n), 16'h0001);
    int_mask = 0;
    tick(2);
    check(16'({int_n, mode}), 16'({1'b0, XCVR_WAKE}));
    rd(16'h0001);
    tick(2);
    check(16'(int_n), 16'h0001);
    done("normal wake");
    cmd(XCVR_OFF);
    chip = CHIP_FAILSAFE;
    tick(3);
    check(16'(mode), 16'(XCVR_WAKE));
    restart_seen = 0;
    wake();
    check(16'({restart_seen, int_n, rx_pin}), 16'h0006);
    rd(16'h0001);
    chip = CHIP_SW_FLASH;
    tick(3);
    check(16'(mode), 16'(XCVR_NORMAL));
    chip = CHIP_FACTORY;
    tick(3);
    check(16'(mode), 16'(XCVR_OFF));
    done("forced modes");
    chip = CHIP_NORMAL;
    cmd(XCVR_NORMAL);
    tx_in = 0;
    tick(14);
    check(16'(drv_dom), 16'h0000);
    tx_in = 1;
    tick(2);
    rd(16'h0002);
    cmd(XCVR_NORMAL);
    tx_in = 0;
    tick(2);
    check(16'(drv_dom), 16'h0001);
    tx_in = 1;
    tick(2);
    done("tx timeout");
    force_dom = 1;
    tick(22);
    force_dom = 0;
    tick(2);
    check(16'({mode, int_n}), 16'({XCVR_RX_ONLY, 1'b0}));
    rd(16'h0004);
    done("bus clamp");
    cmd(XCVR_NORMAL);
    rx_short = 1;
    force_dom = 1;
    tick(12);
    force_dom = 0;
    rx_short = 0;
    tick(2);
    rd(16'h0008);
    done("rx fault");
    uv_off = 1;
    tick(3);
    check(16'(drv_oe), 16'h0000);
    uv_off = 0;
    tick(3);
    check(16'(drv_oe), 16'h0001);
    done("undervoltage");
    print_verdict();
  end
endmodule

// ==== rtl/can_mode_pkg.sv ====
/*
  package for the transceiver mode and wake control block: chip modes, transceiver modes,
  register layout and timing counts.
  assumes a single 250 mhz clock domain.
*/
package can_mode_pkg;
  // transceiver modes, gray along off -> wake -> rx only -> normal
  typedef enum logic [1:0] {
    XCVR_OFF     = 2'h0,
    XCVR_WAKE    = 2'h1,
    XCVR_RX_ONLY = 2'h3,
    XCVR_NORMAL  = 2'h2
  } xcvr_mode_type;

  // chip-level operating modes
  typedef enum logic [2:0] {
    CHIP_INIT     = 3'h0,
    CHIP_NORMAL   = 3'h1,
    CHIP_STOP     = 3'h2,
    CHIP_SLEEP    = 3'h3,
    CHIP_RESTART  = 3'h4,
    CHIP_FAILSAFE = 3'h5,
    CHIP_SW_FLASH = 3'h6,
    CHIP_FACTORY  = 3'h7
  } chip_mode_type;

  // mode command from the serial port
  typedef struct packed {
    logic          valid;
    xcvr_mode_type mode;
  } mode_cmd_type;

  // wake source status register
  localparam logic [2:0] WAKE_STATUS_ADDR = 3'h0;
  localparam int         WAKE_STATUS_W    = 16;
  localparam int         WK_BUS_BIT       = 0;
  localparam int         TXD_TO_BIT       = 1;
  localparam int         BUS_DOM_BIT      = 2;
  localparam int         RXD_FAULT_BIT    = 3;
  localparam logic [15:0] WAKE_STATUS_RST = 16'h0000;

  // timing in ns and cycles at 4 ns
  localparam int CLK_PERIOD_NS     = 4;
  localparam int WAKE_FILTER_NS    = 1000;
  localparam int TXD_TIMEOUT_NS    = 2000000;
  localparam int BUS_DOM_NS        = 2000000;
  localparam int RXD_STUCK_NS      = 2000000;
  localparam int WAKE_FILTER_CYC   = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXD_TIMEOUT_CYC   = (TXD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_DOM_CYC       = (BUS_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RXD_STUCK_CYC     = (RXD_STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 20;
endpackage

// ==== rtl/can_transceiver_mode_control.sv ====
/*
  transceiver mode and wake control: mode selection, tx/rx paths, wake handling, timeouts
  and the wake source status register.
  assumes synchronous inputs, a digitised differential receiver and a serial port decoder
  that delivers mode commands and status read strobes as one-cycle pulses.
*/
// Overview of operation
// RULE1 - normal mode by command in normal/flash/devel; the devel strap enables no chip mode beyond normal
// RULE2 - normal mode drives bus from tx input
// RULE3 - receive output follows differential receiver
// RULE4 - common-mode output only normal or rx-only
// RULE5 - receive output faults recorded in status
// RULE6 - wake capable by command; forced in fail-safe
// RULE7 - after wake, host leaves wake before reselecting
// RULE8 - sleep wake: restart, int high, rx low, flag
// RULE9 - sleep wake no interrupt; status at address 000
// RULE10 - stop wake: stay stop, int low, rx low
// RULE11 - restart/fail-safe wake: restart, int high, flag
// RULE12 - normal wake: flag, int low, rx low
// RULE13 - off mode stops activity, ignores wakes
// RULE14 - off selectable; forced in init and factory
// RULE15 - rx-only disables driver, keeps reception
// RULE16 - supply undervoltage floats both bus pins
// RULE17 - tx dominant timeout stops drive until command
// RULE18 - bus dominant timeout: rx-only, report, interrupt
// RULE19 - wake flag held until status read
// RULE20 - mode field encodes four modes
`timescale 1ns/1ps
module can_transceiver_mode_control
  import can_mode_pkg::*;
#(
  parameter int WAKE_FILTER_P = WAKE_FILTER_CYC,  // wake filter length in cycles
  parameter int TXD_TO_P      = TXD_TIMEOUT_CYC,  // tx dominant timeout in cycles
  parameter int BUS_TO_P      = BUS_DOM_CYC,      // bus dominant timeout in cycles
  parameter int RXD_STUCK_P   = RXD_STUCK_CYC     // rx readback mismatch timeout in cycles
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  input  wire chip_mode_type            i_chip_mode,        // chip operating mode
  input  wire logic                     i_sw_devel,         // software development strap
  input  wire mode_cmd_type             i_mode_cmd,         // mode command pulse
  input  wire logic                     i_status_rd,        // status read pulse
  input  wire logic [2:0]               i_status_addr,      // status read address
  input  wire logic                     i_int_mask,         // masks bus events from int
  input  wire logic                     i_bus_tx_input,     // host tx, 0 = dominant
  input  wire logic                     i_bus_diff,         // receiver, 0 = dominant
  input  wire logic                     i_bus_rx_pin_fb,    // readback of receive pin
  input  wire logic                     i_supply_undervoltage_off,
  output logic                          o_bus_rx_pin,       // receive output
  output logic                          o_drv_dominant,     // drive stages dominant
  output logic                          o_drv_oe,           // output stages enabled
  output logic                          o_split_en,         // common-mode output on
  output logic                          o_int_n,            // interrupt, active low
  output logic                          o_restart_req,      // request chip restart
  output xcvr_mode_type                 o_mode,             // current mode
  output logic [WAKE_STATUS_W-1:0]      o_status_data       // status read data
);
  // state registers
  xcvr_mode_type         mode_q, mode_d;          // RULE20
  logic                  wk_q, wk_d;              // bus wake flag
  logic                  wk_block_q, wk_block_d;  // wake reselect blocked
  logic                  txd_to_q, txd_to_d;      // tx timeout latched
  logic                  bus_dom_q, bus_dom_d;    // bus clamp latched
  logic                  rxd_flt_q, rxd_flt_d;    // rx fault latched
  logic [CNT_W-1:0]      wcnt_q, wcnt_d;          // wake filter count
  logic [CNT_W-1:0]      tcnt_q, tcnt_d;          // tx dominant count
  logic [CNT_W-1:0]      bcnt_q, bcnt_d;          // bus dominant count
  logic [CNT_W-1:0]      rcnt_q, rcnt_d;          // rx stuck count
  logic                  rx_q, rx_d;
  logic                  dom_q, dom_d;
  logic                  oe_q, oe_d;
  logic                  split_q, split_d;
  logic                  int_n_q, int_n_d;
  logic                  rst_req_q, rst_req_d;
  logic [15:0]           sdata_q, sdata_d;
  logic                  wake_evt;                // filtered wake this cycle
  logic                  normal_ok;               // chip allows normal mode
  logic                  rd_hit;                  // status register read

  assign normal_ok = (i_chip_mode == CHIP_NORMAL) || (i_chip_mode == CHIP_SW_FLASH) ||
                     ((i_chip_mode == CHIP_NORMAL) && i_sw_devel);  // RULE1
  assign rd_hit    = i_status_rd && (i_status_addr == WAKE_STATUS_ADDR);  // RULE9
  // a wake is taken once per selection of wake capable mode, then re-arming is needed
  assign wake_evt  = (mode_q == XCVR_WAKE) && (wcnt_q == CNT_W'(WAKE_FILTER_P - 1)) &&
                     !i_bus_diff && !wk_block_q;  // RULE7

  // next state of mode, flags and counters
  always_comb begin
    mode_d     = mode_q;
    wk_d       = wk_q;
    wk_block_d = wk_block_q;
    txd_to_d   = txd_to_q;
    bus_dom_d  = bus_dom_q;
    rxd_flt_d  = rxd_flt_q;
    wcnt_d     = '0;
    tcnt_d     = '0;
    bcnt_d     = '0;
    rcnt_d     = '0;
    // read clears the wake, bus clamp and rx fault flags, set below wins
    if (rd_hit) begin
      wk_d      = 1'b0;  // RULE19
      rxd_flt_d = 1'b0;
      bus_dom_d = 1'b0;
    end
    // command handling
    if (i_mode_cmd.valid) begin
      case (i_mode_cmd.mode)
        XCVR_NORMAL: begin
          if (normal_ok) begin
            mode_d     = XCVR_NORMAL;  // RULE1
            wk_block_d = 1'b0;
            txd_to_d   = 1'b0;         // RULE17
          end
        end
        XCVR_RX_ONLY: begin
          mode_d     = XCVR_RX_ONLY;  // RULE15
          wk_block_d = 1'b0;
        end
        XCVR_OFF: begin
          mode_d     = XCVR_OFF;  // RULE14
          wk_block_d = 1'b0;
        end
        default: begin
          if (!wk_block_q && i_chip_mode != CHIP_SW_FLASH) begin
            mode_d = XCVR_WAKE;  // RULE6 RULE7
          end
        end
      endcase
    end
    // wake filter, counts only in wake capable mode
    if (mode_q == XCVR_WAKE && !i_bus_diff && !wake_evt) begin
      wcnt_d = wcnt_q + CNT_W'(1);
    end
    if (wake_evt) begin
      wk_d       = 1'b1;  // RULE8 RULE10 RULE11 RULE12
      wk_block_d = 1'b1;  // RULE7
    end
    // tx dominant timeout
    if (mode_q == XCVR_NORMAL && !i_bus_tx_input && !txd_to_q) begin
      if (tcnt_q == CNT_W'(TXD_TO_P - 1)) begin
        txd_to_d = 1'b1;  // RULE17
      end else begin
        tcnt_d = tcnt_q + CNT_W'(1);
      end
    end
    // bus dominant clamp
    if ((mode_q == XCVR_NORMAL || mode_q == XCVR_RX_ONLY) && !i_bus_diff) begin
      if (bcnt_q == CNT_W'(BUS_TO_P - 1)) begin
        bus_dom_d = 1'b1;          // RULE18
        mode_d    = XCVR_RX_ONLY;  // RULE18
      end else begin
        bcnt_d = bcnt_q + CNT_W'(1);
      end
    end
    // forced modes by chip mode, placed after the clamp so they win over it
    if (i_chip_mode == CHIP_INIT || i_chip_mode == CHIP_FACTORY) begin
      mode_d = XCVR_OFF;  // RULE14
    end else if (i_chip_mode == CHIP_FAILSAFE && mode_q != XCVR_WAKE) begin
      mode_d = XCVR_WAKE;  // RULE6
    end else if (i_chip_mode == CHIP_SW_FLASH) begin
      mode_d = XCVR_NORMAL;
    end
    // receive pin diagnosis: readback differs from what is driven
    if ((mode_q == XCVR_NORMAL || mode_q == XCVR_RX_ONLY) && (i_bus_rx_pin_fb != rx_q)) begin
      if (rcnt_q == CNT_W'(RXD_STUCK_P - 1)) begin
        rxd_flt_d = 1'b1;  // RULE5
      end else begin
        rcnt_d = rcnt_q + CNT_W'(1);
      end
    end
  end

  // next values of the outputs
  always_comb begin
    rx_d      = 1'b1;
    dom_d     = 1'b0;
    oe_d      = 1'b0;
    split_d   = 1'b0;
    int_n_d   = 1'b1;
    rst_req_d = 1'b0;
    sdata_d   = sdata_q;
    case (mode_q)
      XCVR_NORMAL: begin
        rx_d    = i_bus_diff;          // RULE3
        oe_d    = !txd_to_q;           // RULE17
        dom_d   = !i_bus_tx_input && !txd_to_q;  // RULE2
        split_d = 1'b1;                // RULE4
      end
      XCVR_RX_ONLY: begin
        rx_d    = i_bus_diff;  // RULE15
        split_d = 1'b1;        // RULE4
      end
      XCVR_WAKE: begin
        rx_d = !wk_q;  // RULE8 RULE10 RULE12
      end
      default: begin
        rx_d = 1'b1;  // RULE13
      end
    endcase
    if (i_supply_undervoltage_off) begin
      oe_d  = 1'b0;  // RULE16
      dom_d = 1'b0;
    end
    // interrupt only in stop and normal chip modes
    if (!i_int_mask && (i_chip_mode == CHIP_STOP || i_chip_mode == CHIP_NORMAL) &&
        (wk_q || bus_dom_q)) begin
      int_n_d = 1'b0;  // RULE10 RULE12 RULE18
    end
    // restart request on wake from sleep, restart or fail-safe
    if (wake_evt && (i_chip_mode == CHIP_SLEEP || i_chip_mode == CHIP_RESTART ||
                     i_chip_mode == CHIP_FAILSAFE)) begin
      rst_req_d = 1'b1;  // RULE8 RULE9 RULE11
    end
    if (rd_hit) begin
      sdata_d = '0;
      sdata_d[WK_BUS_BIT]    = wk_q;
      sdata_d[TXD_TO_BIT]    = txd_to_q;
      sdata_d[BUS_DOM_BIT]   = bus_dom_q;
      sdata_d[RXD_FAULT_BIT] = rxd_flt_q;  // RULE5
    end
  end

  // state and output registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q     <= XCVR_OFF;
      wk_q       <= 1'b0;
      wk_block_q <= 1'b0;
      txd_to_q   <= 1'b0;
      bus_dom_q  <= 1'b0;
      rxd_flt_q  <= 1'b0;
      wcnt_q     <= '0;
      tcnt_q     <= '0;
      bcnt_q     <= '0;
      rcnt_q     <= '0;
      rx_q       <= 1'b1;
      dom_q      <= 1'b0;
      oe_q       <= 1'b0;
      split_q    <= 1'b0;
      int_n_q    <= 1'b1;
      rst_req_q  <= 1'b0;
      sdata_q    <= WAKE_STATUS_RST;
    end else begin
      mode_q     <= mode_d;
      wk_q       <= wk_d;
      wk_block_q <= wk_block_d;
      txd_to_q   <= txd_to_d;
      bus_dom_q  <= bus_dom_d;
      rxd_flt_q  <= rxd_flt_d;
      wcnt_q     <= wcnt_d;
      tcnt_q     <= tcnt_d;
      bcnt_q     <= bcnt_d;
      rcnt_q     <= rcnt_d;
      rx_q       <= rx_d;
      dom_q      <= dom_d;
      oe_q       <= oe_d;
      split_q    <= split_d;
      int_n_q    <= int_n_d;
      rst_req_q  <= rst_req_d;
      sdata_q    <= sdata_d;
    end
  end

  assign o_bus_rx_pin   = rx_q;
  assign o_drv_dominant = dom_q;
  assign o_drv_oe       = oe_q;
  assign o_split_en     = split_q;
  assign o_int_n        = int_n_q;
  assign o_restart_req  = rst_req_q;
  assign o_mode         = mode_q;
  assign o_status_data  = sdata_q;

  // assertions
  property p_split;
    @(posedge i_clk) disable iff (!i_nrst)
      o_split_en |-> $past(mode_q == XCVR_NORMAL || mode_q == XCVR_RX_ONLY);
  endproperty
  a_split: assert property (p_split) else $error("split enabled outside active modes"); // RULE4

  property p_uv;
    @(posedge i_clk) disable iff (!i_nrst)
      i_supply_undervoltage_off |=> !o_drv_oe;
  endproperty
  a_uv: assert property (p_uv) else $error("driver enabled in undervoltage"); // RULE16

  property p_rxonly;
    @(posedge i_clk) disable iff (!i_nrst)
      mode_q == XCVR_RX_ONLY |=> !o_drv_oe && o_bus_rx_pin == $past(i_bus_diff);
  endproperty
  a_rxonly: assert property (p_rxonly) else $error("rx-only mode drove the bus"); // RULE15

  property p_tx;
    @(posedge i_clk) disable iff (!i_nrst)
      (mode_q == XCVR_NORMAL && !txd_to_q && !i_supply_undervoltage_off)
        |=> o_drv_dominant == !$past(i_bus_tx_input);
  endproperty
  a_tx: assert property (p_tx) else $error("driver does not follow tx input"); // RULE2

  property p_forced_off;
    @(posedge i_clk) disable iff (!i_nrst)
      (i_chip_mode == CHIP_INIT || i_chip_mode == CHIP_FACTORY) |=> mode_q == XCVR_OFF;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("off mode not forced"); // RULE14

  property p_wake_flag;
    @(posedge i_clk) disable iff (!i_nrst)
      wake_evt |=> wk_q ##1 !o_bus_rx_pin;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake not flagged"); // RULE8

  property p_sleep_noint;
    @(posedge i_clk) disable iff (!i_nrst)
      i_chip_mode == CHIP_SLEEP |=> o_int_n;
  endproperty
  a_sleep_noint: assert property (p_sleep_noint) else $error("interrupt in sleep"); // RULE9

  property p_off_ignore;
    @(posedge i_clk) disable iff (!i_nrst)
      (mode_q == XCVR_OFF && !wk_q) |=> !wk_q;
  endproperty
  a_off_ignore: assert property (p_off_ignore) else $error("wake taken in off mode"); // RULE13

  property p_txto;
    @(posedge i_clk) disable iff (!i_nrst)
      txd_to_q && !i_mode_cmd.valid |=> !o_drv_dominant;
  endproperty
  a_txto: assert property (p_txto) else $error("drive after tx timeout"); // RULE17

  property p_normal_ok;
    @(posedge i_clk) disable iff (!i_nrst)
      (mode_q != XCVR_NORMAL && i_mode_cmd.valid && i_mode_cmd.mode == XCVR_NORMAL &&
       !normal_ok && i_chip_mode != CHIP_SW_FLASH) |=> mode_q != XCVR_NORMAL;
  endproperty
  a_normal_ok: assert property (p_normal_ok) else $error("normal mode in wrong chip mode"); // RULE1

  c_wake: cover property (@(posedge i_clk) disable iff (!i_nrst) wake_evt);
  c_busdom: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(bus_dom_q));
  c_txto: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(txd_to_q));
endmodule
